/* logic/mpes_pkg.sv */
// Purpose: Constants for the module power enable sequencer
// Assumes: 25 MHz clock
// Notes:   Times in microseconds, counts derived in cycles
package mpes_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1000000;
	// Least wait from I/O supply high to pins active and ready
	localparam int unsigned IO_SETTLE_US    = 2000;
	// Ready settling window after enable
	localparam int unsigned CTS_MIN_US      = 100000;
	localparam int unsigned CTS_MAX_US      = 500000;
	// Margin inside the window at which ready is given
	localparam int unsigned CTS_TARGET_US   = 150000;
	localparam int unsigned IO_SETTLE_CYC   = IO_SETTLE_US * CYC_PER_US + 1;
	localparam int unsigned CTS_TARGET_CYC  = CTS_TARGET_US * CYC_PER_US;
	localparam int unsigned CNT_W           = 23;
	// Service mode serial setting
	localparam int unsigned SVC_BAUD        = 38400;
	localparam logic [3:0]  SVC_DATA_BITS   = 4'h8;
	localparam logic [1:0]  SVC_PARITY_NONE = 2'h0;
	localparam logic [1:0]  SVC_STOP_BITS   = 2'h1;
	localparam logic [17:0] SVC_BAUD_W      = 18'h09600;
endpackage

/* logic/mpes_top.sv */
// Purpose: Device side enable and readiness sequencing of the module
// Assumes: Host keeps supply ordering; pins pass two flip-flops
// Notes:   Counts are parameters so simulation may shorten them
`timescale 1ns/1ps

// How it works
// - Ready goes active between 100 and 500 ms after enable rises.
// - Ready only after I/O supply has been high over 2 ms.
// - General pins active only after I/O supply high over 2 ms.
// - General pins active no later than ready.
// - Clear to send is an active low output.
// - Receive data line to host is an active low output.
// - Spare output has no function; held low.
// - Service low forces 38400 8N1 without touching stored settings.
module mpes_top #(
	parameter int unsigned IO_SETTLE_CYC  = mpes_pkg::IO_SETTLE_CYC,
	parameter int unsigned CTS_TARGET_CYC = mpes_pkg::CTS_TARGET_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        MODULE_ENABLE,
	input  wire logic        IO_SUPPLY_OK,
	input  wire logic        REQUEST_TO_SEND_IN_N,
	input  wire logic        HOST_TX_LINE_N,
	input  wire logic        SERVICE_N,
	input  wire logic        CORE_RX_DATA,
	input  wire logic        CORE_CTS_WANT,
	input  wire logic [17:0] STORED_BAUD,
	input  wire logic [3:0]  STORED_DATA_BITS,
	input  wire logic [1:0]  STORED_PARITY,
	input  wire logic [1:0]  STORED_STOP_BITS,
	output logic             CLEAR_TO_SEND_OUT_N,
	output logic             MODULE_RX_LINE_N,
	output logic             SPARE_OUTPUT_PIN,
	output logic             GP_PINS_ACTIVE,
	output logic             CORE_RTS,
	output logic             CORE_TX_DATA,
	output logic             SERVICE_MODE,
	output logic [17:0]      PORT_BAUD,
	output logic [3:0]       PORT_DATA_BITS,
	output logic [1:0]       PORT_PARITY,
	output logic [1:0]       PORT_STOP_BITS
);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; pulled-up inputs reset to their idle high level
	logic [1:0] ena_s_q;
	logic [1:0] io_s_q;
	logic [1:0] rts_s_q;
	logic [1:0] tx_s_q;
	logic [1:0] svc_s_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ena_s_q <= 2'h0;
			io_s_q  <= 2'h0;
			rts_s_q <= 2'h3;
			tx_s_q  <= 2'h3;
			svc_s_q <= 2'h3;
		end else begin
			ena_s_q <= {ena_s_q[0], MODULE_ENABLE};
			io_s_q  <= {io_s_q[0], IO_SUPPLY_OK};
			rts_s_q <= {rts_s_q[0], REQUEST_TO_SEND_IN_N};
			tx_s_q  <= {tx_s_q[0], HOST_TX_LINE_N};
			svc_s_q <= {svc_s_q[0], SERVICE_N};
		end
	end

	logic ena;
	logic io_ok;
	assign ena   = ena_s_q[1];
	assign io_ok = io_s_q[1];

	////////////////////////////////////////////////////////////////////
	// Settling counters
	logic [mpes_pkg::CNT_W-1:0] ena_cnt_q;
	logic [mpes_pkg::CNT_W-1:0] io_cnt_q;
	logic                       ena_done;
	logic                       io_done;

	assign ena_done = (ena_cnt_q == mpes_pkg::CNT_W'(CTS_TARGET_CYC));
	assign io_done  = (io_cnt_q == mpes_pkg::CNT_W'(IO_SETTLE_CYC));

	// Counters hold at target, so done stays up while the inputs stay high
	// Time since enable rose; cleared whenever enable is low
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ena_cnt_q <= '0;
		end else if (!ena) begin
			ena_cnt_q <= '0;
		end else if (!ena_done) begin
			ena_cnt_q <= ena_cnt_q + 1'b1;
		end
	end

	// Time since I/O supply rose while enabled
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			io_cnt_q <= '0;
		end else if (!io_ok || !ena) begin
			io_cnt_q <= '0;
		end else if (!io_done) begin
			io_cnt_q <= io_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer
	// Losing enable drops straight back to off; losing I/O supply does so only from the pins and ready states
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_WAIT  = 2'b01,
		ST_GPIO  = 2'b10,
		ST_READY = 2'b11
	} mpes_state_t;

	mpes_state_t state_q;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF:
					if (ena) begin
						state_q <= ST_WAIT;
					end
				ST_WAIT:
					if (!ena) begin
						state_q <= ST_OFF;
					end else if (io_done) begin
						state_q <= ST_GPIO;
					end
				ST_GPIO:
					if (!ena || !io_ok) begin
						state_q <= ST_OFF;
					end else if (ena_done) begin
						state_q <= ST_READY;
					end
				ST_READY:
					if (!ena || !io_ok) begin
						state_q <= ST_OFF;
					end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin outputs
	// Pins follow the state one edge later, so they always lead ready
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			GP_PINS_ACTIVE <= 1'b0;
		end else begin
			GP_PINS_ACTIVE <= (state_q == ST_GPIO) ||
				(state_q == ST_READY);
		end
	end

	// Ready shows only in the ready state and only while the core wants it
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CLEAR_TO_SEND_OUT_N <= 1'b1;
		end else begin
			CLEAR_TO_SEND_OUT_N <= !((state_q == ST_READY) &&
				CORE_CTS_WANT);
		end
	end

	// Receive line idles high until ready, so the host sees no start bit
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			MODULE_RX_LINE_N <= 1'b1;
		end else begin
			MODULE_RX_LINE_N <= (state_q == ST_READY) ?
				!CORE_RX_DATA : 1'b1;
		end
	end

	// Host lines are ignored until ready; a released line reads idle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CORE_RTS     <= 1'b0;
			CORE_TX_DATA <= 1'b0;
		end else begin
			CORE_RTS     <= (state_q == ST_READY) && !rts_s_q[1];
			CORE_TX_DATA <= (state_q == ST_READY) && !tx_s_q[1];
		end
	end

	assign SPARE_OUTPUT_PIN = 1'b0;

	////////////////////////////////////////////////////////////////////
	// Service mode overrides the port setting, stored values untouched
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			SERVICE_MODE   <= 1'b0;
			PORT_BAUD      <= '0;
			PORT_DATA_BITS <= '0;
			PORT_PARITY    <= '0;
			PORT_STOP_BITS <= '0;
		end else if (!svc_s_q[1]) begin
			SERVICE_MODE   <= 1'b1;
			PORT_BAUD      <= mpes_pkg::SVC_BAUD_W;
			PORT_DATA_BITS <= mpes_pkg::SVC_DATA_BITS;
			PORT_PARITY    <= mpes_pkg::SVC_PARITY_NONE;
			PORT_STOP_BITS <= mpes_pkg::SVC_STOP_BITS;
		end else begin
			SERVICE_MODE   <= 1'b0;
			PORT_BAUD      <= STORED_BAUD;
			PORT_DATA_BITS <= STORED_DATA_BITS;
			PORT_PARITY    <= STORED_PARITY;
			PORT_STOP_BITS <= STORED_STOP_BITS;
		end
	end

endmodule

/* tb/mpes_top_props.sv */
// Purpose: Port level checks of the sequencer
// Assumes: Counts handed down by bind
// Notes:   Watches design inputs and outputs
`timescale 1ns/1ps
module mpes_top_props #(
	parameter int unsigned IO_SETTLE_CYC  = 20,
	parameter int unsigned CTS_TARGET_CYC = 100
) (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        MODULE_ENABLE,
	input wire logic        IO_SUPPLY_OK,
	input wire logic        REQUEST_TO_SEND_IN_N,
	input wire logic        SERVICE_N,
	input wire logic        CORE_RX_DATA,
	input wire logic        CLEAR_TO_SEND_OUT_N,
	input wire logic        MODULE_RX_LINE_N,
	input wire logic        SPARE_OUTPUT_PIN,
	input wire logic        GP_PINS_ACTIVE,
	input wire logic        CORE_RTS,
	input wire logic [17:0] PORT_BAUD,
	input wire logic [3:0]  PORT_DATA_BITS
);
default clocking @(posedge CLK); endclocking
default disable iff (RST);
property p_gp; $fell(CLEAR_TO_SEND_OUT_N) |-> $past(GP_PINS_ACTIVE); endproperty
a_gp: assert property (p_gp) else $error("ready before pins");
property p_io; $fell(CLEAR_TO_SEND_OUT_N) |-> $past(IO_SUPPLY_OK,
	IO_SETTLE_CYC); endproperty
a_io: assert property (p_io) else $error("ready too soon after io");
property p_en; $fell(CLEAR_TO_SEND_OUT_N) |-> $past(MODULE_ENABLE,
	CTS_TARGET_CYC); endproperty
a_en: assert property (p_en) else $error("ready too soon");
property p_gpio; $rose(GP_PINS_ACTIVE) |-> $past(IO_SUPPLY_OK,
	IO_SETTLE_CYC); endproperty
a_gpio: assert property (p_gpio) else $error("pins too soon");
property p_spare; SPARE_OUTPUT_PIN == 1'b0; endproperty
a_spare: assert property (p_spare) else $error("spare driven");
property p_rx; !MODULE_RX_LINE_N |-> $past(CORE_RX_DATA); endproperty
a_rx: assert property (p_rx) else $error("rx line wrong");
property p_svc; !SERVICE_N [*4] |=> PORT_BAUD == 18'h09600 &&
	PORT_DATA_BITS == 4'h8; endproperty
a_svc: assert property (p_svc) else $error("service setting");
property p_rts; REQUEST_TO_SEND_IN_N [*4] |-> !CORE_RTS; endproperty
a_rts: assert property (p_rts) else $error("rts wrong");
endmodule

/* tb/mpes_host.sv */
// Purpose: Host model raising supplies and enable
// Assumes: lag sets I/O supply delay in cycles
// Notes:   Main supply kept inside the model
`timescale 1ns/1ps
module mpes_host (
	input wire logic       clk,
	input wire logic       up,
	input wire logic [7:0] lag,
	output logic           ena,
	output logic           io
);
	logic main_q;
	initial begin
		ena = 0;
		io = 0;
		main_q = 0;
		forever begin
			@(posedge up);
			main_q = 1;
			repeat (3) @(negedge clk);
			ena = 1;
			repeat (lag) @(negedge clk);
			io = 1;
			@(negedge up);
			ena = 0;
			repeat (3) @(negedge clk);
			io = 0;
			main_q = 0;
		end
	end
endmodule

/* tb/mpes_top_tb_top.sv */
// Purpose: Bench of the sequencer
// Assumes: Counts shortened to 20 and 100 cycles
// Notes:   Host model drives enable and I/O supply
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module mpes_top_tb_top;
	logic clk, rst, up, ena, io, rts_n, tx_n, svc_n, rxd, want;
	logic cts_n, rx_n, spare, gp, c_rts, c_tx, svc;
	logic [17:0] baud;
	logic [3:0]  bits;
	logic [1:0]  par, stp;
	logic [7:0]  lag;
	logic [25:0] cfg;
	int          error_cnt, cmp_count, k;
	mpes_host i_host (.clk(clk), .up(up), .lag(lag), .ena(ena), .io(io));
	mpes_top #(.IO_SETTLE_CYC(20), .CTS_TARGET_CYC(100)) i_dut (
		.CLK(clk), .RST(rst), .MODULE_ENABLE(ena), .IO_SUPPLY_OK(io),
		.REQUEST_TO_SEND_IN_N(rts_n), .HOST_TX_LINE_N(tx_n),
		.SERVICE_N(svc_n), .CORE_RX_DATA(rxd), .CORE_CTS_WANT(want),
		.STORED_BAUD(cfg[25:8]), .STORED_DATA_BITS(cfg[7:4]),
		.STORED_PARITY(cfg[3:2]), .STORED_STOP_BITS(cfg[1:0]),
		.CLEAR_TO_SEND_OUT_N(cts_n), .MODULE_RX_LINE_N(rx_n),
		.SPARE_OUTPUT_PIN(spare), .GP_PINS_ACTIVE(gp), .CORE_RTS(c_rts),
		.CORE_TX_DATA(c_tx), .SERVICE_MODE(svc), .PORT_BAUD(baud),
		.PORT_DATA_BITS(bits), .PORT_PARITY(par), .PORT_STOP_BITS(stp));
	task automatic boot(input int l, input int lo);
		lag = l[7:0];
		{rts_n, tx_n} = 2'h3;
		up = 1;
		k = 0;
		while (cts_n !== 1'b0 && k < 400) begin
			@(negedge clk);
			k++;
		end
		`CHK(k > lo && k < lo + 12, 1'b1)
		`CHK(gp, 1'b1)
		$display("boot done %0d", k);
	endtask
	task automatic pins;
		rxd = 1;
		rts_n = 0;
		tx_n = 0;
		repeat (5) @(negedge clk);
		`CHK({rx_n, c_rts, c_tx, spare}, 4'h6)
		rxd = 0;
		rts_n = 1;
		tx_n = 1;
		repeat (5) @(negedge clk);
		`CHK({rx_n, c_rts, c_tx}, 3'h4)
		want = 0;
		repeat (2) @(negedge clk);
		`CHK(cts_n, 1'b1)
		want = 1;
		repeat (2) @(negedge clk);
		`CHK(cts_n, 1'b0)
		$display("pins done");
	endtask
	task automatic service;
		svc_n = 0;
		repeat (5) @(negedge clk);
		`CHK({svc, baud, bits, par, stp}, {1'b1, 18'h09600, 8'h81})
		svc_n = 1;
		repeat (5) @(negedge clk);
		`CHK({svc, baud, bits, par, stp}, {1'b0, 18'h01c20, 8'h7a})
		$display("service done");
	endtask
	task automatic down;
		up = 0;
		repeat (6) @(negedge clk);
		`CHK({cts_n, gp}, 2'h2)
		repeat (8) @(negedge clk);
		{rts_n, tx_n} = 2'h0;
		$display("down done");
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst, up, rts_n, tx_n, svc_n, rxd, lag} = {6'h2e, 8'h05};
		{want, cfg} = {1'b1, 18'h01c20, 8'h7a};
		repeat (4) @(negedge clk);
		rst = 0;
		boot(5, 103);
		pins;
		service;
		down;
		boot(150, 173);
		down;
		close_out;
	end
	initial begin
		#60us;
		error_cnt++;
		close_out;
	end
endmodule
bind mpes_top mpes_top_props #(.IO_SETTLE_CYC(IO_SETTLE_CYC),
	.CTS_TARGET_CYC(CTS_TARGET_CYC)) i_props (.*);
